/* include/rps_regs.svh */
// Offsets, field positions, reset values and timing figures of the sequencer
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH
// Register byte offsets on the APB
`define RPS_CTRL_OFS 12'h000
`define RPS_STAT_OFS 12'h004
// Control register fields
`define RPS_CTRL_SLEEP 0
`define RPS_CTRL_SOFTRST 1
`define RPS_CTRL_RST 32'h0000_0000
// Status register fields
`define RPS_STAT_INRST 0
`define RPS_STAT_AWAKE 1
`define RPS_STAT_BOOTWP 2
`define RPS_STAT_NANDWP 3
`define RPS_STAT_BOOTBLK 4
`define RPS_STAT_NANDBLK 5
`define RPS_STAT_STRAP 6
// Clock rate and documented times
`define RPS_CLK_HZ 25000000
`define RPS_EXIT_MS 1000
`define RPS_PULSE_MS 500
`define RPS_REF_HZ 14318000
`define RPS_NCO_BITS 24
`endif

/* include/rps_pkg.sv */
// Types of the module-side end of the reset and power sequencer
package rps_pkg;
    // Device sequencing states, one-hot
    typedef enum logic [2:0] {
        RPS_ST_RESET = 3'b001,
        RPS_ST_RUN = 3'b010,
        RPS_ST_SLEEP = 3'b100
    } rps_state_t;
    // Cycle counter type for long holds
    typedef logic [31:0] rps_cnt_t;
endpackage : rps_pkg

/* include/rps_link_if.sv */
// Pin-level link between the module sequencer and the baseboard logic
`timescale 1ns/1ps
interface rps_link_if;
    logic ext_rst_out;      // Baseboard drive value of reset request
    logic ext_rst_oe;       // Baseboard pulls request low while high
    logic ext_rst_n;        // Resolved request, pulled high
    logic rst_ind_out;      // Device drive value of reset indication
    logic rst_ind_oe;       // Device pulls indication low while high
    logic rst_ind_n;        // Resolved indication, pulled high
    logic boot_flash_protect_n; // Boot flash protect level
    logic nand_protect_n;   // NAND protect level
    logic power_button_input;   // Wake request level
    logic sleep_n;          // Device awake, main rail may be on
    logic reference_clock_output;   // Reference clock from device
    logic strap_out;        // Baseboard drive value on strap pin
    logic strap_oe;         // Baseboard drives strap pin
    logic strap_pin;        // Resolved strap, weak low when undriven
    // Pull-ups and open-drain resolution
    assign ext_rst_n = (ext_rst_oe && !ext_rst_out) ? 1'b0 : 1'b1;
    assign rst_ind_n = (rst_ind_oe && !rst_ind_out) ? 1'b0 : 1'b1;
    assign strap_pin = strap_oe ? strap_out : 1'b0;
    modport dev (
        input ext_rst_n, boot_flash_protect_n, nand_protect_n,
        input power_button_input, strap_pin,
        output rst_ind_out, rst_ind_oe, sleep_n, reference_clock_output
    );
    modport board (
        input rst_ind_n, sleep_n, reference_clock_output,
        output ext_rst_out, ext_rst_oe, boot_flash_protect_n,
        output nand_protect_n, power_button_input, strap_out, strap_oe
    );
endinterface : rps_link_if

/* hw/rps_sync.sv */
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/1ps
module rps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff; // First stage, read only by second
    logic [W-1:0] q_ff;    // Second stage
    // Two flops in series, frozen while clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= INIT;
            q_ff <= INIT;
        end else if (ce) begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule : rps_sync

/* hw/rps_device.sv */
// Module-side reset, write-protect and power sequencer with APB registers
`timescale 1ns/1ps
`include "rps_regs.svh"
module rps_device #(
    parameter int CLK_HZ = `RPS_CLK_HZ,
    parameter longint EXIT_CYC =
        (64'(`RPS_EXIT_MS) * 64'(CLK_HZ)) / 64'd1000,
    parameter longint PULSE_CYC =
        (64'(`RPS_PULSE_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000,
    parameter longint REF_HZ = `RPS_REF_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_wr_req,
    input wire logic nand_wr_req,
    output logic boot_wr_en,
    output logic nand_wr_en,
    output logic sys_reset_n,
    output logic strap_value,
    rps_link_if.dev lnk
);
    localparam int NB = `RPS_NCO_BITS;
    // NCO increment: reference rate as fraction of the clock
    localparam longint STEP_L = (REF_HZ << NB) / 64'(CLK_HZ);
    localparam logic [NB-1:0] STEP = STEP_L[NB-1:0];
    localparam logic [31:0] EXIT_C = EXIT_CYC[31:0];
    localparam logic [31:0] PULSE_C = PULSE_CYC[31:0];
    // Synchronised pin levels
    logic [3:0] pins_s;
    logic ext_n_s;   // Reset request, high when idle
    logic boot_wp_s; // Boot flash protect, low blocks
    logic nand_wp_s; // NAND protect, low blocks
    logic btn_s;     // Power button level
    logic btn_prev_ff;
    logic btn_rise;
    rps_sync #(
        .W(4),
        .INIT(4'hE)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d({lnk.ext_rst_n, lnk.boot_flash_protect_n,
            lnk.nand_protect_n, lnk.power_button_input}),
        .q(pins_s)
    );
    assign ext_n_s = pins_s[3];
    assign boot_wp_s = pins_s[2];
    assign nand_wp_s = pins_s[1];
    assign btn_s = pins_s[0];
    assign btn_rise = btn_s && !btn_prev_ff;
    // State and counters
    rps_pkg::rps_state_t state_ff;
    rps_pkg::rps_state_t nxt_state;
    rps_pkg::rps_cnt_t exit_cnt_ff;  // Cycles since request released
    rps_pkg::rps_cnt_t pulse_cnt_ff; // Cycles since reset entry
    logic sleep_req_ff;   // Software asks for power down
    logic soft_rst_ff;    // Software reset pulse
    logic boot_blk_ff;    // Sticky: a boot flash write was refused
    logic nand_blk_ff;    // Sticky: a NAND write was refused
    logic strap_ff;       // Strap level caught at reset exit
    logic rst_oe_ff;
    logic sleep_n_ff;
    logic sys_rst_n_ff;
    logic boot_en_ff;
    logic nand_en_ff;
    logic [NB-1:0] nco_ff;
    logic ref_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic apb_wr;         // Write takes effect this edge
    logic ctrl_hit;
    logic stat_hit;
    logic reset_done;
    // Write strobe at the access edge with pready high
    assign apb_wr = psel && penable && pready_ff && pwrite;
    assign ctrl_hit = (paddr == `RPS_CTRL_OFS);
    assign stat_hit = (paddr == `RPS_STAT_OFS);
    assign reset_done = (exit_cnt_ff >= EXIT_C) &&
                        (pulse_cnt_ff >= PULSE_C);
    // Next state of the sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rps_pkg::RPS_ST_RESET: begin
                if (reset_done) begin
                    nxt_state = rps_pkg::RPS_ST_RUN;
                end
            end
            rps_pkg::RPS_ST_RUN: begin
                if (!ext_n_s || soft_rst_ff) begin
                    nxt_state = rps_pkg::RPS_ST_RESET;
                end else if (sleep_req_ff) begin
                    nxt_state = rps_pkg::RPS_ST_SLEEP;
                end
            end
            rps_pkg::RPS_ST_SLEEP: begin
                // Wake by button or external reset restarts the board
                if (btn_rise || !ext_n_s) begin
                    nxt_state = rps_pkg::RPS_ST_RESET;
                end
            end
            default: begin
                nxt_state = rps_pkg::RPS_ST_RESET;
            end
        endcase
    end
    // State register; reset release is itself the power-on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= rps_pkg::RPS_ST_RESET;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end
    // Exit count restarts while request low; pulse counts from entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exit_cnt_ff <= '0;
            pulse_cnt_ff <= '0;
        end else if (ce) begin
            if (nxt_state != rps_pkg::RPS_ST_RESET || !ext_n_s) begin
                exit_cnt_ff <= '0;
            end else if (exit_cnt_ff < EXIT_C) begin
                exit_cnt_ff <= exit_cnt_ff + 32'h0000_0001;
            end
            if (nxt_state != rps_pkg::RPS_ST_RESET) begin
                pulse_cnt_ff <= '0;
            end else if (pulse_cnt_ff < PULSE_C) begin
                pulse_cnt_ff <= pulse_cnt_ff + 32'h0000_0001;
            end
        end
    end
    // Pin-facing outputs follow the next state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_oe_ff <= 1'b1;
            sys_rst_n_ff <= 1'b0;
            sleep_n_ff <= 1'b1;
            btn_prev_ff <= 1'b0;
        end else if (ce) begin
            rst_oe_ff <= (nxt_state == rps_pkg::RPS_ST_RESET);
            sys_rst_n_ff <= (nxt_state == rps_pkg::RPS_ST_RUN);
            sleep_n_ff <= (nxt_state != rps_pkg::RPS_ST_SLEEP);
            btn_prev_ff <= btn_s;
        end
    end
    // Flash write gating, shut during reset; strap caught at reset exit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_en_ff <= 1'b0;
            nand_en_ff <= 1'b0;
            strap_ff <= 1'b0;
        end else if (ce) begin
            boot_en_ff <= boot_wr_req && boot_wp_s && sys_rst_n_ff;
            nand_en_ff <= nand_wr_req && nand_wp_s && sys_rst_n_ff;
            if (state_ff == rps_pkg::RPS_ST_RESET && reset_done) begin
                strap_ff <= lnk.strap_pin;
            end
        end
    end
    // Sticky refusal flags; a new refusal beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_blk_ff <= 1'b0;
            nand_blk_ff <= 1'b0;
        end else if (ce) begin
            if (boot_wr_req && !boot_wp_s) begin
                boot_blk_ff <= 1'b1;
            end else if (apb_wr && stat_hit &&
                         pwdata[`RPS_STAT_BOOTBLK]) begin
                boot_blk_ff <= 1'b0;
            end
            if (nand_wr_req && !nand_wp_s) begin
                nand_blk_ff <= 1'b1;
            end else if (apb_wr && stat_hit &&
                         pwdata[`RPS_STAT_NANDBLK]) begin
                nand_blk_ff <= 1'b0;
            end
        end
    end
    // Control register: sleep request and soft reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_req_ff <= 1'(`RPS_CTRL_RST >> `RPS_CTRL_SLEEP);
            soft_rst_ff <= 1'(`RPS_CTRL_RST >> `RPS_CTRL_SOFTRST);
        end else if (ce) begin
            if (apb_wr && ctrl_hit) begin
                sleep_req_ff <= pwdata[`RPS_CTRL_SLEEP];
                soft_rst_ff <= pwdata[`RPS_CTRL_SOFTRST];
            end else begin
                soft_rst_ff <= 1'b0;
                // Request is consumed once asleep so a wake sticks
                if (state_ff == rps_pkg::RPS_ST_SLEEP) begin
                    sleep_req_ff <= 1'b0;
                end
            end
        end
    end
    // APB answer: no wait state, data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else if (ce) begin
            pready_ff <= psel && !penable;
            if (psel && !penable) begin
                pslverr_ff <= !(ctrl_hit || stat_hit);
                prdata_ff <= '0;
                if (!pwrite && ctrl_hit) begin
                    prdata_ff[`RPS_CTRL_SLEEP] <= sleep_req_ff;
                end else if (!pwrite && stat_hit) begin
                    prdata_ff[`RPS_STAT_INRST] <= rst_oe_ff;
                    prdata_ff[`RPS_STAT_AWAKE] <= sleep_n_ff;
                    prdata_ff[`RPS_STAT_BOOTWP] <= boot_wp_s;
                    prdata_ff[`RPS_STAT_NANDWP] <= nand_wp_s;
                    prdata_ff[`RPS_STAT_BOOTBLK] <= boot_blk_ff;
                    prdata_ff[`RPS_STAT_NANDBLK] <= nand_blk_ff;
                    prdata_ff[`RPS_STAT_STRAP] <= strap_ff;
                end
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end
    // Reference clock: phase accumulator, carry drives the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nco_ff <= '0;
            ref_ff <= 1'b0;
        end else if (ce) begin
            {ref_ff, nco_ff} <= {1'b0, nco_ff} + {1'b0, STEP};
        end
    end
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign boot_wr_en = boot_en_ff;
    assign nand_wr_en = nand_en_ff;
    assign sys_reset_n = sys_rst_n_ff;
    assign strap_value = strap_ff;
    assign lnk.rst_ind_out = 1'b0;
    assign lnk.rst_ind_oe = rst_oe_ff;
    assign lnk.sleep_n = sleep_n_ff;
    assign lnk.reference_clock_output = ref_ff;
endmodule : rps_device

/* hw/rps_board.sv */
// Baseboard-side supply, reset request and strap control
`timescale 1ns/1ps
module rps_board (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic standby_req,
    input wire logic reset_req,
    input wire logic boot_protect_req,
    input wire logic nand_protect_req,
    input wire logic button_req,
    input wire logic strap_drive_req,
    input wire logic strap_level,
    output logic standby_supply,
    output logic main_supply_rail,
    output logic board_reset_n,
    rps_link_if.board lnk
);
    logic [1:0] pins_s;  // Synchronised sleep and reset indication
    logic standby_ff;    // Standby supply enable
    logic main_ff;       // Main rail enable
    logic brst_ff;       // Board reset follows indication
    logic ext_oe_ff;
    logic bwp_ff;
    logic nwp_ff;
    logic btn_ff;
    logic strap_oe_ff;
    logic strap_out_ff;

    rps_sync #(
        .W(2),
        .INIT(2'h0)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d({lnk.sleep_n, lnk.rst_ind_n}),
        .q(pins_s)
    );

    // Supply sequencing: standby first, main only while awake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_ff <= 1'b0;
            main_ff <= 1'b0;
        end else if (ce) begin
            standby_ff <= standby_req;
            main_ff <= standby_ff && standby_req && pins_s[1];
        end
    end

    // Request and protect drives; strap released while device resets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_oe_ff <= 1'b0;
            bwp_ff <= 1'b1;
            nwp_ff <= 1'b1;
            btn_ff <= 1'b0;
            strap_oe_ff <= 1'b0;
            strap_out_ff <= 1'b0;
            brst_ff <= 1'b0;
        end else if (ce) begin
            ext_oe_ff <= reset_req;
            bwp_ff <= !boot_protect_req;
            nwp_ff <= !nand_protect_req;
            btn_ff <= button_req && standby_ff;
            strap_oe_ff <= strap_drive_req && pins_s[0];
            strap_out_ff <= strap_level;
            brst_ff <= pins_s[0];
        end
    end

    assign standby_supply = standby_ff;
    assign main_supply_rail = main_ff;
    assign board_reset_n = brst_ff;
    assign lnk.ext_rst_out = 1'b0;
    assign lnk.ext_rst_oe = ext_oe_ff;
    assign lnk.boot_flash_protect_n = bwp_ff;
    assign lnk.nand_protect_n = nwp_ff;
    assign lnk.power_button_input = btn_ff;
    assign lnk.strap_out = strap_out_ff;
    assign lnk.strap_oe = strap_oe_ff;
endmodule : rps_board

/* tb/rps_link_sva.sv */
// Link-level checks of the reset and power sequencer
`timescale 1ns/1ps
module rps_link_sva #(
    parameter int EXIT_CYC = 20,
    parameter int PULSE_CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_rst_oe,
    input wire logic ext_rst_n,
    input wire logic rst_ind_oe,
    input wire logic rst_ind_n,
    input wire logic strap_oe,
    input wire logic reference_clock_output
);
    logic [15:0] hi_cnt_ff; // Cycles since request pin went high
    logic [15:0] oe_cnt_ff; // Length of the current indication pulse
    logic [3:0] gap_cnt_ff; // Cycles since last reference high
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Request-high time, cleared by a request, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_cnt_ff <= '0;
        else if (!ext_rst_n) hi_cnt_ff <= '0;
        else if (hi_cnt_ff != 16'hFFFF) hi_cnt_ff <= hi_cnt_ff + 16'h0001;
    end
    // Indication pulse length, cleared while released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) oe_cnt_ff <= '0;
        else if (!rst_ind_oe) oe_cnt_ff <= '0;
        else if (oe_cnt_ff != 16'hFFFF) oe_cnt_ff <= oe_cnt_ff + 16'h0001;
    end
    // Reference idle run, cleared on each high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap_cnt_ff <= '0;
        else if (reference_clock_output) gap_cnt_ff <= '0;
        else if (gap_cnt_ff != 4'hF) gap_cnt_ff <= gap_cnt_ff + 4'h1;
    end
    property p_req_forces;
        !ext_rst_n [*5] |-> rst_ind_oe;
    endproperty
    a_req_forces: assert property (p_req_forces)
        else $error("reset request did not force reset");
    property p_exit_min;
        $fell(rst_ind_oe) |-> hi_cnt_ff >= EXIT_CYC;
    endproperty
    a_exit_min: assert property (p_exit_min)
        else $error("reset left too early after request release");
    property p_exit_max;
        ext_rst_n && hi_cnt_ff == 16'(EXIT_CYC + 6) |-> !rst_ind_oe;
    endproperty
    a_exit_max: assert property (p_exit_max)
        else $error("reset held too long after request release");
    property p_por;
        $rose(presetn) |-> rst_ind_oe && !ext_rst_oe;
    endproperty
    a_por: assert property (p_por)
        else $error("no power-on reset without a request");
    property p_ind_low;
        rst_ind_oe |-> !rst_ind_n;
    endproperty
    a_ind_low: assert property (p_ind_low)
        else $error("reset indication not low during reset");
    property p_pulse_len;
        $fell(rst_ind_oe) |-> oe_cnt_ff >= PULSE_CYC;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset indication pulse too short");
    property p_strap_quiet;
        !rst_ind_n [*5] |-> !strap_oe;
    endproperty
    a_strap_quiet: assert property (p_strap_quiet)
        else $error("strap pin driven during boot");
    property p_ref_runs;
        gap_cnt_ff < 4'h4;
    endproperty
    a_ref_runs: assert property (p_ref_runs)
        else $error("reference clock stopped low");
    property p_ref_falls;
        reference_clock_output [*3] |=> !reference_clock_output;
    endproperty
    a_ref_falls: assert property (p_ref_falls)
        else $error("reference clock stuck high");
endmodule : rps_link_sva

/* tb/testbench.sv */
// Self-checking bench joining the module and baseboard sequencers
`timescale 1ns/1ps
`include "rps_regs.svh"
module testbench;
    localparam int EXIT_N = 20; // Shortened one-second hold
    localparam int PULSE_N = 10; // Shortened half-second pulse
    logic pclk, presetn, ce, psel, penable, pwrite; // Clock, reset, APB
    logic [11:0] paddr; // APB address
    logic [31:0] pwdata, prdata; // APB data
    logic pready, pslverr; // APB answer
    logic boot_wr_req, nand_wr_req, boot_wr_en, nand_wr_en; // Flash writes
    logic sys_reset_n, strap_value; // Device state outputs
    logic standby_req, reset_req, boot_protect_req, nand_protect_req;
    logic button_req, strap_drive_req, strap_level; // Board requests
    logic standby_supply, main_supply_rail, board_reset_n; // Board outputs
    logic [31:0] d; // Read data
    logic e; // Read error
    int n, k, error_cnt, n_tests, cyc_cnt; // Counters
    rps_link_if lnk();
    rps_device #(.EXIT_CYC(EXIT_N), .PULSE_CYC(PULSE_N)) u_rps_device (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_wr_req(boot_wr_req),
        .nand_wr_req(nand_wr_req), .boot_wr_en(boot_wr_en),
        .nand_wr_en(nand_wr_en), .sys_reset_n(sys_reset_n),
        .strap_value(strap_value), .lnk(lnk));
    rps_board u_rps_board (
        .pclk(pclk), .presetn(presetn), .ce(ce), .standby_req(standby_req),
        .reset_req(reset_req), .boot_protect_req(boot_protect_req),
        .nand_protect_req(nand_protect_req), .button_req(button_req),
        .strap_drive_req(strap_drive_req), .strap_level(strap_level),
        .standby_supply(standby_supply),
        .main_supply_rail(main_supply_rail),
        .board_reset_n(board_reset_n), .lnk(lnk));
    rps_link_sva #(.EXIT_CYC(EXIT_N), .PULSE_CYC(PULSE_N)) u_rps_link_sva (
        .pclk(pclk), .presetn(presetn), .ext_rst_oe(lnk.ext_rst_oe),
        .ext_rst_n(lnk.ext_rst_n), .rst_ind_oe(lnk.rst_ind_oe),
        .rst_ind_n(lnk.rst_ind_n), .strap_oe(lnk.strap_oe),
        .reference_clock_output(lnk.reference_clock_output));
    // Free-running bus clock
    always #20 pclk = ~pclk;
    // Hang guard
    always @(posedge pclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Report and stop
    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Compare one value
    task automatic check(input string nm, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Let cycles pass
    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask : tick
    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Bounded wait for the run state
    task automatic wait_run();
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 500) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_run
    // Main sequence
    initial begin
        pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; boot_wr_req = 0; nand_wr_req = 0;
        standby_req = 0; reset_req = 0; boot_protect_req = 0;
        nand_protect_req = 0; button_req = 0; strap_drive_req = 0;
        strap_level = 0; error_cnt = 0; n_tests = 0; cyc_cnt = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        check("ind_por", 32'(lnk.rst_ind_n), 32'h0);
        wait_run();
        check("por_exit", 32'(n >= EXIT_N && n < 40), 32'h1);
        apb(1'b0, `RPS_CTRL_OFS, '0);
        check("ctrl_rst", d, `RPS_CTRL_RST);
        apb(1'b0, `RPS_STAT_OFS, '0);
        check("stat_run", d & 32'h3, 32'h2);
        apb(1'b0, 12'h008, '0);
        check("bad_err", 32'(e), 32'h1);
        check("bad_data", d, 32'h0);
        check("rail_nostby", 32'(main_supply_rail), 32'h0);
        standby_req <= 1'b1;
        tick(8);
        check("stby_on", 32'(standby_supply), 32'h1);
        check("rail_on", 32'(main_supply_rail), 32'h1);
        // Every protect combination against pending writes
        for (int i = 0; i < 4; i++) begin
            boot_protect_req <= i[0];
            nand_protect_req <= i[1];
            boot_wr_req <= 1'b1;
            nand_wr_req <= 1'b1;
            tick(8);
            check("boot_en", 32'(boot_wr_en), 32'(!i[0]));
            check("nand_en", 32'(nand_wr_en), 32'(!i[1]));
            apb(1'b0, `RPS_STAT_OFS, '0);
            check("stat_prot", 32'(d[3:2]), 32'({!i[1], !i[0]}));
        end
        check("stat_refused", (d >> 4) & 32'h3, 32'h3);
        boot_protect_req <= 1'b0;
        nand_protect_req <= 1'b0;
        tick(6);
        apb(1'b1, `RPS_STAT_OFS, 32'h30);
        apb(1'b0, `RPS_STAT_OFS, '0);
        check("stat_clear", (d >> 4) & 32'h3, 32'h0);
        // Sleep, rail drop, button wake
        apb(1'b1, `RPS_CTRL_OFS, 32'h1);
        tick(6);
        check("sleep", 32'(lnk.sleep_n), 32'h0);
        check("rail_off", 32'(main_supply_rail), 32'h0);
        check("en_asleep", 32'(boot_wr_en), 32'h0);
        apb(1'b0, `RPS_CTRL_OFS, '0);
        check("ctrl_sleep", d & 32'h1, 32'h0);
        button_req <= 1'b1;
        tick(4);
        button_req <= 1'b0;
        wait_run();
        tick(8);
        check("wake", 32'(lnk.sleep_n), 32'h1);
        check("rail_back", 32'(main_supply_rail), 32'h1);
        // External request while the board drives the strap
        strap_level <= 1'b1;
        strap_drive_req <= 1'b1;
        tick(6);
        check("strap_run", 32'(lnk.strap_pin), 32'h1);
        reset_req <= 1'b1;
        tick(10);
        check("ext_rst", 32'(sys_reset_n), 32'h0);
        check("ind_ext", 32'(board_reset_n), 32'h0);
        reset_req <= 1'b0;
        wait_run();
        check("ext_exit", 32'(n >= EXIT_N && n <= EXIT_N + 10), 32'h1);
        check("strap_boot", 32'(strap_value), 32'h0);
        strap_drive_req <= 1'b0;
        // Soft reset pulse
        apb(1'b1, `RPS_CTRL_OFS, 32'h2);
        tick(2);
        check("soft_rst", 32'(sys_reset_n), 32'h0);
        wait_run();
        check("soft_exit", 32'(n >= PULSE_N - 4 && n < 40), 32'h1);
        // Reference carries in 1000 cycles, about 572.7 expected
        k = 0;
        repeat (1000) begin
            @(posedge pclk);
            if (lnk.reference_clock_output === 1'b1) k++;
        end
        check("ref_rate", 32'(k >= 570 && k <= 575), 32'h1);
        print_verdict();
    end
endmodule : testbench
